// File: logic/lsc_top.sv
// limit switch conditioning for four axes with an axi4-lite register slave
`timescale 1ns/10ps
module lsc_top
   import lsc_pkg::*;
#(
   parameter int TICK_CYCLES = SEC_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // axi4-lite slave
   input wire logic [AW-1:0] S_AWADDR,
   input wire logic S_AWVALID,
   output logic S_AWREADY,
   input wire logic [31:0] S_WDATA,
   input wire logic [3:0] S_WSTRB,
   input wire logic S_WVALID,
   output logic S_WREADY,
   output logic [1:0] S_BRESP,
   output logic S_BVALID,
   input wire logic S_BREADY,
   input wire logic [AW-1:0] S_ARADDR,
   input wire logic S_ARVALID,
   output logic S_ARREADY,
   output logic [31:0] S_RDATA,
   output logic [1:0] S_RRESP,
   output logic S_RVALID,
   input wire logic S_RREADY,
   // switch pins, three per axis: lower, reference, upper
   input wire logic [SW_BITS-1:0] SW_IN,
   // motion engine events and state
   input wire logic [AXES-1:0] HOME_DONE,
   input wire logic [AXES-1:0] RANGE_DONE,
   input wire logic [AXES-1:0] HOME_ACTIVE,
   // axis control outputs
   output logic [AXES-1:0] LOWER_LIMIT,
   output logic [AXES-1:0] UPPER_LIMIT,
   output logic [AXES-1:0] SPEED_CAP,
   output logic [AXES-1:0] RANGE_STOP_EN,
   output logic [2*AXES-1:0] LIMIT_CAPTURE,
   output logic [AXES-1:0] HOME_EXPIRED
);
   logic [SW_BITS-1:0] s_pin;
   logic [3:0] swap;
   logic [3:0] dirinv;
   logic [11:0] en;
   logic [11:0] pol;
   logic [2:0] raw_idx;
   logic [6:0] tmo;
   logic [31:0] prog;
   logic [11:0] act_rep;
   logic [7:0] raw_rep;
   logic [AXES-1:0] homed;
   logic [AXES-1:0] ranged;
   logic [AXES-1:0] xch;
   logic [AXES-1:0] up_eff;
   logic [11:0] act_ph;
   lsc_ch_e wr_st;
   lsc_ch_e rd_st;
   logic aw_held;
   logic w_held;
   logic [AW-1:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic do_write;
   logic wr_ok;
   logic next_aw_held;
   logic next_w_held;
   logic next_bvalid;
   logic next_rvalid;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic [24:0] tick_cnt;
   logic tick;
   logic [6:0] sec_cnt [AXES];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nv[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic pick(input logic exchange, input logic lo, input logic up);
      return exchange ? up : lo;
   endfunction : pick

   lsc_sync #(.W(SW_BITS)) u_sync (
      .CORE_CLK(CORE_CLK),
      .RST(RST),
      .D(SW_IN),
      .Q(s_pin)
   );

   // switch conditioning
   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         xch[a] = swap[a] ^ dirinv[a];
         up_eff[a] = pick(xch[a], en[3*a+F_UPPER], en[3*a+F_LOWER]);
      end
      for (int i = 0; i < SW_BITS; i++) begin
         act_ph[i] = (s_pin[i] == pol[i]) & en[i];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         LOWER_LIMIT <= '0;
         UPPER_LIMIT <= '0;
         act_rep <= '0;
         raw_rep <= '0;
      end else begin
         for (int a = 0; a < AXES; a++) begin
            // reference bit never reaches the role outputs
            LOWER_LIMIT[a] <= pick(xch[a], act_ph[3*a+F_LOWER], act_ph[3*a+F_UPPER]);
            UPPER_LIMIT[a] <= pick(xch[a], act_ph[3*a+F_UPPER], act_ph[3*a+F_LOWER]);
            act_rep[a] <= pick(xch[a], act_ph[3*a+F_LOWER], act_ph[3*a+F_UPPER]);
            act_rep[AXES+a] <= act_ph[3*a+F_REF];
            act_rep[2*AXES+a] <= pick(xch[a], act_ph[3*a+F_UPPER], act_ph[3*a+F_LOWER]);
            raw_rep[2*a] <= s_pin[3*a+F_LOWER];
            raw_rep[2*a+1] <= s_pin[3*a+F_UPPER];
         end
      end
   end

   // progress report and speed cap
   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         homed[a] = prog[2*a +: 2] == PROG_HOMED;
         ranged[a] = prog[2*(AXES+a) +: 2] == PROG_RANGED;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         prog <= '0;
      end else begin
         for (int a = 0; a < AXES; a++) begin
            // a set in the same cycle as a software clear wins
            if (do_write && wa == OFS_EVENT && ws[2] && wd[EV_CLEAR]) begin
               prog[2*a +: 2] <= PROG_NONE;
               prog[2*(AXES+a) +: 2] <= PROG_NONE;
               prog[2*(2*AXES+a) +: 2] <= PROG_NONE;
               prog[2*(3*AXES+a) +: 2] <= PROG_NONE;
            end
            if (HOME_DONE[a]) begin
               prog[2*a +: 2] <= PROG_HOMED;
            end
            if (RANGE_DONE[a]) begin
               prog[2*(AXES+a) +: 2] <= PROG_RANGED;
            end
            if (do_write && wa == OFS_EVENT && ws[1] && wd[EV_LIM_LO+a]) begin
               prog[2*(2*AXES+a) +: 2] <= PROG_LIMIT;
            end
            if (do_write && wa == OFS_EVENT && ws[1] && wd[EV_LIM_HI+a]) begin
               prog[2*(3*AXES+a) +: 2] <= PROG_LIMIT;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         SPEED_CAP <= '0;
         RANGE_STOP_EN <= '0;
         LIMIT_CAPTURE <= '0;
      end else begin
         for (int a = 0; a < AXES; a++) begin
            SPEED_CAP[a] <= (|en[3*a +: 3]) & ~(homed[a] & (~up_eff[a] | ranged[a]));
            RANGE_STOP_EN[a] <= homed[a] & ranged[a];
            LIMIT_CAPTURE[a] <= HOME_DONE[a];
            LIMIT_CAPTURE[AXES+a] <= RANGE_DONE[a];
         end
      end
   end

   // homing timeout on a one-second tick
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= tick_cnt == 25'(TICK_CYCLES - 1);
         tick_cnt <= (tick_cnt == 25'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 25'h000_0001;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         HOME_EXPIRED <= '0;
         for (int a = 0; a < AXES; a++) begin
            sec_cnt[a] <= '0;
         end
      end else begin
         for (int a = 0; a < AXES; a++) begin
            if (!HOME_ACTIVE[a]) begin
               sec_cnt[a] <= '0;
            end else if (tick && sec_cnt[a] != 7'h7f) begin
               sec_cnt[a] <= sec_cnt[a] + 7'h01;
            end
            HOME_EXPIRED[a] <= HOME_ACTIVE[a] && sec_cnt[a] >= tmo;
         end
      end
   end

   // axi4-lite write channel
   assign do_write = aw_held && w_held && wr_st == CH_IDLE;
   assign wr_ok = wa == OFS_SWAP || wa == OFS_DIRINV || wa == OFS_ENABLE ||
                  wa == OFS_ENABLE_ALL || wa == OFS_POLARITY || wa == OFS_RAW_ONE ||
                  wa == OFS_EVENT || wa == OFS_TIMEOUT;

   always_comb begin
      next_aw_held = do_write ? 1'b0 : (aw_held | (S_AWVALID & S_AWREADY));
      next_w_held = do_write ? 1'b0 : (w_held | (S_WVALID & S_WREADY));
      next_bvalid = do_write | (S_BVALID & ~S_BREADY);
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         wr_st <= CH_IDLE;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         S_AWREADY <= 1'b0;
         S_WREADY <= 1'b0;
         S_BVALID <= 1'b0;
         S_BRESP <= RESP_OKAY;
         wa <= '0;
         wd <= '0;
         ws <= '0;
      end else begin
         if (S_AWVALID && S_AWREADY) begin
            wa <= {S_AWADDR[AW-1:2], 2'b00};
         end
         if (S_WVALID && S_WREADY) begin
            wd <= S_WDATA;
            ws <= S_WSTRB;
         end
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         S_BVALID <= next_bvalid;
         wr_st <= next_bvalid ? CH_RESP : CH_IDLE;
         S_AWREADY <= ~next_aw_held & ~next_bvalid;
         S_WREADY <= ~next_w_held & ~next_bvalid;
         if (do_write) begin
            S_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // software registers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         swap <= SWAP_RST;
         dirinv <= DIRINV_RST;
         en <= ENABLE_RST;
         pol <= POLARITY_RST;
         raw_idx <= '0;
         tmo <= TIMEOUT_RST;
      end else if (do_write) begin
         case (wa)
            OFS_SWAP: swap <= 4'(merge(32'(swap), wd, ws));
            OFS_DIRINV: dirinv <= 4'(merge(32'(dirinv), wd, ws));
            OFS_ENABLE: en <= 12'(merge(32'(en), wd, ws));
            OFS_ENABLE_ALL: begin
               if (ws[0]) begin
                  en <= {4{wd[2:0]}};
               end
            end
            OFS_POLARITY: pol <= 12'(merge(32'(pol), wd, ws));
            OFS_RAW_ONE: raw_idx <= 3'(merge(32'(raw_idx), wd, ws));
            OFS_TIMEOUT: tmo <= 7'(merge(32'(tmo), wd, ws));
            default: begin
            end
         endcase
      end
   end

   // axi4-lite read channel
   always_comb begin
      rd_ok = 1'b1;
      case ({S_ARADDR[AW-1:2], 2'b00})
         OFS_SWAP: rd_mux = 32'(swap);
         OFS_DIRINV: rd_mux = 32'(dirinv);
         OFS_ENABLE: rd_mux = 32'(en);
         OFS_ENABLE_ALL: rd_mux = 32'h0000_0000;
         OFS_POLARITY: rd_mux = 32'(pol);
         OFS_ACTUATION: rd_mux = 32'(act_rep);
         OFS_RAW: rd_mux = 32'(raw_rep);
         OFS_RAW_ONE: rd_mux = 32'({raw_idx, 3'b000, raw_rep[raw_idx]});
         OFS_PROGRESS: rd_mux = prog;
         OFS_EVENT: rd_mux = 32'h0000_0000;
         OFS_CAP: rd_mux = 32'({RANGE_STOP_EN, SPEED_CAP});
         OFS_TIMEOUT: rd_mux = 32'(tmo);
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   assign next_rvalid = (S_ARVALID & S_ARREADY) | ((rd_st == CH_RESP) & ~S_RREADY);

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rd_st <= CH_IDLE;
         S_ARREADY <= 1'b0;
         S_RVALID <= 1'b0;
         S_RDATA <= '0;
         S_RRESP <= RESP_OKAY;
      end else begin
         S_RVALID <= next_rvalid;
         rd_st <= next_rvalid ? CH_RESP : CH_IDLE;
         S_ARREADY <= ~next_rvalid;
         if (S_ARVALID && S_ARREADY) begin
            S_RDATA <= rd_mux;
            S_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // checks
   unswapped_role_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (!swap[0] && !dirinv[0] && en[0] && s_pin[0] == pol[0]) |=> LOWER_LIMIT[0])
      else $error("unswapped lower switch not reported on lower role");
   swapped_role_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (swap[1] && !dirinv[1] && en[3] && s_pin[3] == pol[3]) |=> UPPER_LIMIT[1])
      else $error("swapped lower switch not reported on upper role");
   double_swap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (swap[2] && dirinv[2] && en[8] && s_pin[8] == pol[8]) |=> UPPER_LIMIT[2])
      else $error("swap and invert together must cancel");
   disabled_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (en == 12'h000) ##1 (en == 12'h000) |-> act_rep == 12'h000 && LOWER_LIMIT == 4'h0)
      else $error("disabled switch reported actuated");
   raw_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      raw_rep[7] == $past(s_pin[11]) && raw_rep[0] == $past(s_pin[0]))
      else $error("raw level order or value wrong");
   cap_free_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (en[2:0] == 3'b000) |=> !SPEED_CAP[0])
      else $error("cap applied to axis without switches");
   cap_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (en[5:3] == 3'b101 && !ranged[1]) |=> SPEED_CAP[1])
      else $error("cap lifted before range measure");
   cap_lift_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (HOME_DONE[1] && en[5:3] == 3'b011 && !xch[1]) ##1 (en[5:3] == 3'b011 && !xch[1])
      |=> !SPEED_CAP[1])
      else $error("cap not lifted after homing with upper disabled");
   prog_home_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      HOME_DONE[0] |=> (prog[1:0] == PROG_HOMED) && LIMIT_CAPTURE[0])
      else $error("homing not recorded in progress");
   read_answer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (S_ARVALID && S_ARREADY) |=> S_RVALID && !S_ARREADY)
      else $error("read answer not one cycle after address");
endmodule : lsc_top

// File: logic/lsc_pkg.sv
// constants shared by the limit switch conditioning block
package lsc_pkg;
   localparam int AXES = 4;
   localparam int SW_PER_AXIS = 3;
   localparam int SW_BITS = 12;
   localparam int AW = 8;
   // register byte offsets
   localparam logic [AW-1:0] OFS_SWAP = 8'h00;
   localparam logic [AW-1:0] OFS_DIRINV = 8'h04;
   localparam logic [AW-1:0] OFS_ENABLE = 8'h08;
   localparam logic [AW-1:0] OFS_ENABLE_ALL = 8'h0c;
   localparam logic [AW-1:0] OFS_POLARITY = 8'h10;
   localparam logic [AW-1:0] OFS_ACTUATION = 8'h14;
   localparam logic [AW-1:0] OFS_RAW = 8'h18;
   localparam logic [AW-1:0] OFS_RAW_ONE = 8'h1c;
   localparam logic [AW-1:0] OFS_PROGRESS = 8'h20;
   localparam logic [AW-1:0] OFS_EVENT = 8'h24;
   localparam logic [AW-1:0] OFS_CAP = 8'h28;
   localparam logic [AW-1:0] OFS_TIMEOUT = 8'h2c;
   // field positions inside one axis group of enable, polarity and pins
   localparam int F_LOWER = 0;
   localparam int F_REF = 1;
   localparam int F_UPPER = 2;
   // raw single-read register: index in, index echoed at this position
   localparam int RAW_IDX_POS = 4;
   // event register fields
   localparam int EV_LIM_LO = 8;
   localparam int EV_LIM_HI = 12;
   localparam int EV_CLEAR = 16;
   // cap register fields
   localparam int CAP_STOP_POS = 4;
   // reset values
   localparam logic [3:0] SWAP_RST = 4'h0;
   localparam logic [3:0] DIRINV_RST = 4'h0;
   localparam logic [11:0] ENABLE_RST = 12'hfff;
   localparam logic [11:0] POLARITY_RST = 12'h000;
   // progress character codes, two bits each
   localparam logic [1:0] PROG_NONE = 2'h0;
   localparam logic [1:0] PROG_HOMED = 2'h1;
   localparam logic [1:0] PROG_RANGED = 2'h2;
   localparam logic [1:0] PROG_LIMIT = 2'h3;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int HOME_TIMEOUT_S = 40;
   localparam int SEC_CYCLES = CLK_HZ * 1;
   localparam logic [6:0] TIMEOUT_RST = 7'(HOME_TIMEOUT_S);
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [0:0] {
      CH_IDLE = 1'b0,
      CH_RESP = 1'b1
   } lsc_ch_e;
endpackage : lsc_pkg

// File: logic/lsc_sync.sv
// two-stage synchroniser for the switch pins
`timescale 1ns/10ps
module lsc_sync #(
   parameter int W = 12
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // data
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         meta <= '0;
         Q <= '0;
      end else begin
         meta <= D;
         Q <= meta;
      end
   end
endmodule : lsc_sync

// File: sim/lsc_stage.sv
// behavioural model of the stage switches and the motion engine
`timescale 1ns/10ps
module lsc_stage (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // commands from the bench
   input wire logic [11:0] pins,
   input wire logic [3:0] home_go,
   input wire logic [3:0] range_go,
   input wire logic [7:0] delay,
   // towards the block
   output logic [11:0] sw_in,
   output logic [3:0] home_done,
   output logic [3:0] range_done,
   output logic [3:0] home_active
);
   logic [7:0] cnt [4];
   logic [3:0] is_rng;

   // switch levels follow the stage position directly
   assign sw_in = pins;

   // each move runs for delay+1 cycles, then ends with one done pulse
   always_ff @(posedge CORE_CLK) begin
      for (int a = 0; a < 4; a++) begin
         home_done[a] <= 1'b0;
         range_done[a] <= 1'b0;
         if (RST) begin
            home_active[a] <= 1'b0;
            cnt[a] <= 8'h00;
            is_rng[a] <= 1'b0;
         end else if (home_go[a] | range_go[a]) begin
            home_active[a] <= 1'b1;
            cnt[a] <= delay;
            is_rng[a] <= range_go[a];
         end else if (home_active[a]) begin
            if (cnt[a] == 8'h00) begin
               home_active[a] <= 1'b0;
               range_done[a] <= is_rng[a];
               home_done[a] <= !is_rng[a];
            end else begin
               cnt[a] <= cnt[a] - 8'h01;
            end
         end
      end
   end
endmodule : lsc_stage

// File: sim/testbench.sv
// self-checking bench for the limit switch conditioning block
`timescale 1ns/10ps
module testbench;
   import lsc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, dly = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] home_go = 4'h0, range_go = 4'h0;
   logic awr, wrdy, bvalid, arr, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] sw;
   logic [3:0] hd, rdn, ha, lo, up, cap, stop, expd;
   logic [7:0] lcap;
   // reference model state
   logic [3:0] m_swap = 4'h0, m_inv = 4'h0, homed = 4'h0, ranged = 4'h0;
   logic [11:0] m_en = 12'hfff, m_pol = 12'h000, pins = 12'h000;
   int prog [16] = '{default: 0};
   int miscompares = 0, n_checks = 0, n_capture = 0, seed = 32'hca5c;

   initial begin
      forever #20 clk = ~clk;
   end

   lsc_top #(.TICK_CYCLES(10)) i_dut (
      .CORE_CLK(clk), .RST(rst), .S_AWADDR(awa), .S_AWVALID(awv), .S_AWREADY(awr),
      .S_WDATA(wd), .S_WSTRB(4'hf), .S_WVALID(wv), .S_WREADY(wrdy), .S_BRESP(bresp),
      .S_BVALID(bvalid), .S_BREADY(bry), .S_ARADDR(ara), .S_ARVALID(arv), .S_ARREADY(arr),
      .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rry), .SW_IN(sw),
      .HOME_DONE(hd), .RANGE_DONE(rdn), .HOME_ACTIVE(ha), .LOWER_LIMIT(lo), .UPPER_LIMIT(up),
      .SPEED_CAP(cap), .RANGE_STOP_EN(stop), .LIMIT_CAPTURE(lcap), .HOME_EXPIRED(expd));

   lsc_stage i_stage (
      .CORE_CLK(clk), .RST(rst), .pins(pins), .home_go(home_go), .range_go(range_go),
      .delay(dly), .sw_in(sw), .home_done(hd), .range_done(rdn), .home_active(ha));

   // counts every limit capture pulse
   always @(posedge clk) begin
      if (!rst) n_capture <= n_capture + $countones(lcap);
   end

   function automatic logic [11:0] exp_act();
      logic [11:0] a;
      logic [11:0] r;
      for (int x = 0; x < 12; x++) a[x] = (pins[x] == m_pol[x]) & m_en[x];
      for (int x = 0; x < 4; x++) begin
         r[x] = (m_swap[x] ^ m_inv[x]) ? a[3*x+2] : a[3*x];
         r[4+x] = a[3*x+1];
         r[8+x] = (m_swap[x] ^ m_inv[x]) ? a[3*x] : a[3*x+2];
      end
      return r;
   endfunction : exp_act

   function automatic logic [7:0] exp_raw();
      logic [7:0] r;
      for (int x = 0; x < 4; x++) begin
         r[2*x] = pins[3*x];
         r[2*x+1] = pins[3*x+2];
      end
      return r;
   endfunction : exp_raw

   function automatic logic [7:0] exp_cap();
      logic [7:0] r;
      logic ue;
      for (int x = 0; x < 4; x++) begin
         ue = (m_swap[x] ^ m_inv[x]) ? m_en[3*x] : m_en[3*x+2];
         r[x] = (m_en[3*x +: 3] != 3'b000) && !(homed[x] && (!ue || ranged[x]));
         r[4+x] = homed[x] && ranged[x];
      end
      return r;
   endfunction : exp_cap

   function automatic logic [31:0] exp_prog();
      logic [31:0] r;
      for (int p = 0; p < 16; p++) r[2*p +: 2] = prog[p][1:0];
      return r;
   endfunction : exp_prog

   task automatic test_done();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic hang();
      chk(32'h0000_0000, 32'h0000_0001);
      test_done();
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      awa <= a;
      awv <= 1'b1;
      wd <= d;
      wv <= 1'b1;
      bry <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bry <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rvalid) begin
            v = rdata;
            r = rresp;
            rry <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      @(posedge clk);
   endtask : rd

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask : wreg

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] r;
      rd(a, v, r);
      chk(32'(r), 32'(RESP_OKAY));
      chk(v, e);
   endtask : rchk

   // waits until every move of the stage model has ended
   task automatic wait_idle();
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if (ha === 4'h0) break;
      end
      if (n == 300) hang();
      repeat (3) @(posedge clk);
   endtask : wait_idle

   initial begin
      logic [31:0] v;
      logic [1:0] r;
      logic [11:0] ea;
      logic [7:0] ex;
      int i, n;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values and bus refusals
      rchk(OFS_SWAP, 32'h0000_0000);
      rchk(OFS_DIRINV, 32'h0000_0000);
      rchk(OFS_ENABLE, 32'h0000_0fff);
      rchk(OFS_POLARITY, 32'h0000_0000);
      rchk(OFS_TIMEOUT, 32'h0000_0028);
      rchk(OFS_PROGRESS, exp_prog());
      rchk(OFS_CAP, {24'h0, exp_cap()});
      rd(8'h3c, v, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(OFS_ACTUATION, 32'h0000_0fff, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rchk(OFS_ACTUATION, {20'h0, exp_act()});
      // random swap, invert, enable, polarity and pin levels
      for (i = 0; i < 16; i++) begin
         m_swap = 4'($random(seed));
         m_inv = 4'($random(seed));
         m_en = 12'($random(seed));
         m_pol = 12'($random(seed));
         if (i % 2 == 1) m_en[8:6] = 3'b000;
         wreg(OFS_SWAP, {28'h0, m_swap});
         wreg(OFS_DIRINV, {28'h0, m_inv});
         wreg(OFS_ENABLE, {20'h0, m_en});
         wreg(OFS_POLARITY, {20'h0, m_pol});
         pins <= 12'($random(seed));
         repeat (4) @(posedge clk);
         ea = exp_act();
         ex = exp_raw();
         rchk(OFS_ACTUATION, {20'h0, ea});
         chk({24'h0, up, lo}, {24'h0, ea[11:8], ea[3:0]});
         rchk(OFS_RAW, {24'h0, ex});
         rchk(OFS_CAP, {24'h0, exp_cap()});
         wreg(OFS_RAW_ONE, 32'(i % 8));
         rchk(OFS_RAW_ONE, {25'h0, 3'(i % 8), 3'h0, ex[i % 8]});
      end
      // one enable triple for every axis
      n = $random(seed);
      wreg(OFS_ENABLE_ALL, 32'(n));
      m_en = {4{n[2:0]}};
      rchk(OFS_ENABLE, {20'h0, m_en});
      rchk(OFS_ENABLE_ALL, 32'h0000_0000);
      wreg(OFS_ENABLE_ALL, 32'h0000_0000);
      m_en = 12'h000;
      rchk(OFS_ACTUATION, {20'h0, exp_act()});
      rchk(OFS_CAP, {24'h0, exp_cap()});
      // homing then range measure with mixed enables
      m_swap = 4'h0;
      m_inv = 4'h0;
      m_en = 12'he1f;
      wreg(OFS_SWAP, 32'h0000_0000);
      wreg(OFS_DIRINV, 32'h0000_0000);
      wreg(OFS_ENABLE, {20'h0, m_en});
      rchk(OFS_CAP, {24'h0, exp_cap()});
      home_go <= 4'hf;
      @(posedge clk);
      home_go <= 4'h0;
      wait_idle();
      homed = 4'hf;
      for (i = 0; i < 4; i++) prog[i] = 1;
      rchk(OFS_CAP, {24'h0, exp_cap()});
      rchk(OFS_PROGRESS, exp_prog());
      dly <= 8'd20;
      range_go <= 4'h9;
      @(posedge clk);
      range_go <= 4'h0;
      wait_idle();
      ranged = 4'h9;
      prog[4] = 2;
      prog[7] = 2;
      rchk(OFS_CAP, {24'h0, exp_cap()});
      chk({24'h0, stop, cap}, {24'h0, exp_cap()});
      rchk(OFS_PROGRESS, exp_prog());
      // soft limit events, then a clear of all progress
      wreg(OFS_EVENT, 32'h0000_a500);
      prog[8] = 3;
      prog[10] = 3;
      prog[13] = 3;
      prog[15] = 3;
      rchk(OFS_PROGRESS, exp_prog());
      wreg(OFS_EVENT, 32'h0001_0000);
      for (i = 0; i < 16; i++) prog[i] = 0;
      rchk(OFS_PROGRESS, exp_prog());
      homed = 4'h0;
      ranged = 4'h0;
      rchk(OFS_CAP, {24'h0, exp_cap()});
      // homing move that outlasts a two second timeout
      wreg(OFS_TIMEOUT, 32'h0000_0002);
      dly <= 8'd200;
      home_go <= 4'h8;
      @(posedge clk);
      home_go <= 4'h0;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (expd[3] === 1'b1) break;
      end
      chk(32'(n >= 9 && n <= 24), 32'h0000_0001);
      wait_idle();
      chk(32'(expd), 32'h0000_0000);
      chk(32'(n_capture), 32'd7);
      test_done();
   end
endmodule : testbench
